//--- src/hcsi_core.sv
// cycle status decoder, address latches and ready handshake toward the system controller
`timescale 1ns/10ps
module hcsi_core (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic sys_rst_in,
	// system controller status pins
	input wire logic cycle_status0_n_in,
	output logic cycle_status0_n_out,
	output logic cycle_status0_n_oe_out,
	input wire logic cycle_status1_n_in,
	output logic cycle_status1_n_out,
	output logic cycle_status1_n_oe_out,
	input wire logic mem_io_select_in,
	input wire logic early_addr_latch_n_in,
	input wire logic onboard_dram_sel_n_in,
	input wire logic addr_bit20_block_n_in,
	input wire logic cpu_hold_ack_in,
	output logic channel_ready_n_out,
	// local address bus
	input wire logic [25:2] local_addr_in,
	input wire logic [3:0] byte_en_n_in,
	// slot side
	output logic slot_clock_out,
	output logic [23:17] latched_upper_addr_out,
	output logic latched_addr_bit20_out,
	output logic [19:0] slot_addr_out,
	output logic slot_addr_bit20_out,
	output logic slot_high_byte_en_n_out,
	output logic bus_drive_en_out,
	output logic mem_rd_n_out,
	output logic mem_wr_n_out,
	output logic io_rd_n_out,
	output logic io_wr_n_out,
	output logic int_ack_n_out,
	// slot command engine and dma side
	input wire logic cycle_done_in,
	input wire logic dma_mem_wr_n_in,
	input wire logic dma_mem_rd_n_in
);
	logic [hcsi_pkg::SYNC_W-1:0] sync1_q;
	logic [hcsi_pkg::SYNC_W-1:0] sync2_q;
	logic [hcsi_pkg::SYNC_W-1:0] raw;
	logic s0_act, s1_act, mem_sel, early_addr_latch_n_n, dram_n, blk_n, hold;
	logic [hcsi_pkg::ADDR_W-1:0] addr_s;
	logic [3:0] be_s;
	hcsi_pkg::hcsi_state_t state_q, state_d;
	hcsi_pkg::hcsi_kind_t kind_q, kind_d;
	logic mem_q, mem_d, req_prev_q, req_act, req_edge, hold_q;
	logic [hcsi_pkg::ADDR_W-1:0] lat_q, lat_d;
	logic [3:0] be_q, be_d;
	logic [19:0] sa_q, sa_d;
	logic slot_high_byte_en_n_q, slot_high_byte_en_n_d, sclk_q, sclk_d, rdy_q, rdy_d;
	logic mr_q, mr_d, mw_q, mw_d, ir_q, ir_d, iw_q, iw_d, ia_q, ia_d;
	logic [1:0] low_sel;
	logic a20;

	assign raw = {cycle_status0_n_in, cycle_status1_n_in, mem_io_select_in,
		early_addr_latch_n_in, onboard_dram_sel_n_in, addr_bit20_block_n_in,
		cpu_hold_ack_in, local_addr_in, byte_en_n_in};

	// first stage samples on the falling edge; only the second stage reads it
	always_ff @(negedge ref_clk_in) begin
		if (sys_rst_in) begin
			sync1_q <= hcsi_pkg::SYNC_RST;
		end else begin
			sync1_q <= raw;
		end
	end

	assign s0_act = ~sync2_q[34];
	assign s1_act = ~sync2_q[33];
	assign mem_sel = sync2_q[32];
	assign early_addr_latch_n_n = sync2_q[31];
	assign dram_n = sync2_q[30];
	assign blk_n = sync2_q[29];
	assign hold = sync2_q[28];
	assign addr_s = sync2_q[27:4];
	assign be_s = sync2_q[3:0];
	// status sampled while we still drove the pins is our own strobe, not a request
	assign req_act = (s0_act | s1_act) & ~hold & ~hold_q;
	assign req_edge = req_act & ~req_prev_q;

	always_comb begin
		state_d = state_q;
		kind_d = kind_q;
		mem_d = mem_q;
		lat_d = lat_q;
		be_d = be_q;
		sa_d = sa_q;
		slot_high_byte_en_n_d = slot_high_byte_en_n_q;
		low_sel = 2'h3;
		sclk_d = ~sclk_q;
		if (!early_addr_latch_n_n) begin
			lat_d = addr_s;
			be_d = be_s;
		end
		// lowest enabled byte lane gives the two low slot address bits
		if (!be_q[0]) begin
			low_sel = 2'h0;
		end else if (!be_q[1]) begin
			low_sel = 2'h1;
		end else if (!be_q[2]) begin
			low_sel = 2'h2;
		end
		case (state_q)
			hcsi_pkg::HCSI_IDLE: begin
				if (req_edge) begin
					sa_d = {lat_q[hcsi_pkg::SA_HI_W-1:0], low_sel};
					slot_high_byte_en_n_d = be_q[1] & be_q[3];
					mem_d = mem_sel;
					if (s0_act && s1_act) begin
						kind_d = hcsi_pkg::HCSI_INTA;
					end else if (s0_act) begin
						kind_d = hcsi_pkg::HCSI_WR;
					end else begin
						kind_d = hcsi_pkg::HCSI_RD;
					end
					state_d = hcsi_pkg::HCSI_CMD;
				end
			end
			hcsi_pkg::HCSI_CMD: begin
				if (cycle_done_in) begin
					state_d = hcsi_pkg::HCSI_END;
				end
			end
			hcsi_pkg::HCSI_END: begin
				state_d = hcsi_pkg::HCSI_IDLE;
			end
			default: begin
				state_d = hcsi_pkg::HCSI_IDLE;
			end
		endcase
		// ready is low in idle and once the cycle can complete
		rdy_d = (state_d == hcsi_pkg::HCSI_CMD);
		// on-board memory cycles stay off the slot memory strobes
		mr_d = ~((state_d != hcsi_pkg::HCSI_IDLE) && kind_d == hcsi_pkg::HCSI_RD && mem_d
			&& dram_n);
		mw_d = ~((state_d != hcsi_pkg::HCSI_IDLE) && kind_d == hcsi_pkg::HCSI_WR && mem_d
			&& dram_n);
		ir_d = ~((state_d != hcsi_pkg::HCSI_IDLE) && kind_d == hcsi_pkg::HCSI_RD && !mem_d);
		iw_d = ~((state_d != hcsi_pkg::HCSI_IDLE) && kind_d == hcsi_pkg::HCSI_WR && !mem_d);
		ia_d = ~((state_d != hcsi_pkg::HCSI_IDLE) && kind_d == hcsi_pkg::HCSI_INTA);
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			sync2_q <= hcsi_pkg::SYNC_RST;
			state_q <= hcsi_pkg::HCSI_IDLE;
			kind_q <= hcsi_pkg::HCSI_RD;
			mem_q <= 1'b0;
			req_prev_q <= 1'b0;
			hold_q <= 1'b1;
			lat_q <= hcsi_pkg::ADDR_RST;
			be_q <= 4'hF;
			sa_q <= hcsi_pkg::SA_RST;
			slot_high_byte_en_n_q <= 1'b1;
			sclk_q <= 1'b0;
			rdy_q <= 1'b0;
			mr_q <= 1'b1;
			mw_q <= 1'b1;
			ir_q <= 1'b1;
			iw_q <= 1'b1;
			ia_q <= 1'b1;
		end else begin
			sync2_q <= sync1_q;
			state_q <= state_d;
			kind_q <= kind_d;
			mem_q <= mem_d;
			req_prev_q <= req_act;
			hold_q <= hold;
			lat_q <= lat_d;
			be_q <= be_d;
			sa_q <= sa_d;
			slot_high_byte_en_n_q <= slot_high_byte_en_n_d;
			sclk_q <= sclk_d;
			rdy_q <= rdy_d;
			mr_q <= mr_d;
			mw_q <= mw_d;
			ir_q <= ir_d;
			iw_q <= iw_d;
			ia_q <= ia_d;
		end
	end

	// block forcing only applies in cpu mode; masters see the real bit
	assign a20 = lat_q[hcsi_pkg::A20_POS] & ~(~hold & ~blk_n);
	assign latched_upper_addr_out = lat_q[hcsi_pkg::UP_LSB +: hcsi_pkg::UP_W];
	assign latched_addr_bit20_out = a20;
	assign slot_addr_bit20_out = a20;
	assign slot_addr_out = sa_q;
	assign slot_high_byte_en_n_out = slot_high_byte_en_n_q;
	assign slot_clock_out = sclk_q;
	assign channel_ready_n_out = rdy_q;
	assign bus_drive_en_out = ~hold;
	assign cycle_status0_n_oe_out = hold;
	assign cycle_status1_n_oe_out = hold;
	assign cycle_status0_n_out = dma_mem_wr_n_in;
	assign cycle_status1_n_out = dma_mem_rd_n_in;
	assign mem_rd_n_out = mr_q;
	assign mem_wr_n_out = mw_q;
	assign io_rd_n_out = ir_q;
	assign io_wr_n_out = iw_q;
	assign int_ack_n_out = ia_q;

	ready_idle_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		(state_q == hcsi_pkg::HCSI_IDLE) |-> !channel_ready_n_out)
		else $error("channel ready not asserted while idle");
	ready_neg_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		(state_q == hcsi_pkg::HCSI_IDLE && req_edge) |=> channel_ready_n_out)
		else $error("channel ready not negated on request");
	ready_hold_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		(channel_ready_n_out && !cycle_done_in) |=> channel_ready_n_out)
		else $error("channel ready not held negated during the cycle");
	ready_back_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		(channel_ready_n_out && cycle_done_in) |=> !channel_ready_n_out)
		else $error("channel ready not reasserted when the cycle can complete");
	cmd_end_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		$fell(channel_ready_n_out) |=> (mem_rd_n_out && mem_wr_n_out && io_rd_n_out
		&& io_wr_n_out && int_ack_n_out))
		else $error("command still active after ready reasserted");
	write_dec_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		(state_q == hcsi_pkg::HCSI_IDLE && req_edge && s0_act && !s1_act && !mem_sel)
		|=> !io_wr_n_out && io_rd_n_out)
		else $error("write status not decoded as write");
	read_dec_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		(state_q == hcsi_pkg::HCSI_IDLE && req_edge && s1_act && !s0_act && mem_sel && dram_n)
		##1 dram_n |-> !mem_rd_n_out && mem_wr_n_out)
		else $error("read status not decoded as memory read");
	inta_dec_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		(state_q == hcsi_pkg::HCSI_IDLE && req_edge && s0_act && s1_act)
		|=> !int_ack_n_out && io_rd_n_out && io_wr_n_out && mem_rd_n_out && mem_wr_n_out)
		else $error("both status active not decoded as acknowledge");
	slot_clk_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		!sys_rst_in |=> slot_clock_out != $past(slot_clock_out))
		else $error("slot clock not at half rate");
	a20_block_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		(!hold && !blk_n) |-> !latched_addr_bit20_out && !slot_addr_bit20_out)
		else $error("bit 20 not blocked");
	status_dir_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		hold |-> cycle_status0_n_oe_out && cycle_status1_n_oe_out && !bus_drive_en_out)
		else $error("status pins not turned around under hold");
	relatch_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		(state_q == hcsi_pkg::HCSI_IDLE && req_edge)
		|=> slot_addr_out[19:2] == $past(lat_q[17:0]))
		else $error("slot address not relatched on request");
	latch_hold_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
		early_addr_latch_n_n |=> $stable(latched_upper_addr_out))
		else $error("address latch moved while closed");
endmodule : hcsi_core

//--- src/hcsi_pkg.sv
// package of constants and types for the host cycle status interface
package hcsi_pkg;
	localparam int ADDR_W = 24;
	localparam int BE_W = 4;
	localparam int CTRL_W = 7;
	localparam int SYNC_W = CTRL_W + ADDR_W + BE_W;
	localparam int UP_LSB = 15;
	localparam int UP_W = 7;
	localparam int A20_POS = 18;
	localparam int SA_HI_W = 18;
	localparam logic [SYNC_W-1:0] SYNC_RST = 35'h7_FFFF_FFFF;
	localparam logic [19:0] SA_RST = 20'h0_0000;
	localparam logic [ADDR_W-1:0] ADDR_RST = 24'h00_0000;
	typedef enum logic [1:0] {HCSI_IDLE, HCSI_CMD, HCSI_END} hcsi_state_t;
	typedef enum logic [1:0] {HCSI_WR, HCSI_RD, HCSI_INTA} hcsi_kind_t;
endpackage : hcsi_pkg

//--- test/hcsi_sc_model.sv
// system controller model: status pins, address and latch strobe
`timescale 1ns/10ps
module hcsi_sc_model (
	// clock and device pin drive
	input wire logic clk_in,
	input wire logic s0_oe_in,
	input wire logic s0_dev_in,
	input wire logic s1_oe_in,
	input wire logic s1_dev_in,
	// toward the device
	output logic s0_pin_out,
	output logic s1_pin_out,
	output logic mio_out,
	output logic latch_n_out,
	output logic dram_n_out,
	output logic [25:2] addr_out,
	output logic [3:0] be_n_out
);
	logic s0_n_q;
	logic s1_n_q;
	// the device owns the status pins under hold
	assign s0_pin_out = s0_oe_in ? s0_dev_in : s0_n_q;
	assign s1_pin_out = s1_oe_in ? s1_dev_in : s1_n_q;
	initial {s0_n_q, s1_n_q, mio_out, latch_n_out, dram_n_out, addr_out, be_n_out} = {5'h1B, 28'hF};
	task automatic request(input logic s0, s1, mio, dram_n, input logic [25:2] a);
		@(posedge clk_in);
		{addr_out, be_n_out, mio_out, dram_n_out, latch_n_out} <= {a, 4'hD, mio, dram_n, 1'b0};
		repeat (3) @(posedge clk_in);
		{latch_n_out, s0_n_q, s1_n_q} <= {1'b1, ~s0, ~s1};
		repeat (3) @(posedge clk_in);
		// past the hold time show the inverse, never the old value
		{addr_out, be_n_out} <= {~a, 4'h2};
	endtask : request
endmodule : hcsi_sc_model

//--- test/testbench.sv
// self-checking bench for the host cycle status interface
`timescale 1ns/10ps
module testbench;
	localparam logic [25:2] TA = 24'h67_5C3D;
	logic ref_clk_in = 1'b0, sys_rst_in = 1'b1, cycle_done_in = 1'b0, cpu_hold_ack_in = 1'b0;
	logic dma_mem_wr_n_in = 1'b0, dma_mem_rd_n_in = 1'b1, addr_bit20_block_n_in = 1'b1;
	logic cycle_status0_n_in, cycle_status1_n_in, mem_io_select_in, early_addr_latch_n_in;
	logic onboard_dram_sel_n_in, channel_ready_n_out, slot_clock_out, bus_drive_en_out;
	logic cycle_status0_n_out, cycle_status0_n_oe_out, cycle_status1_n_out, int_ack_n_out;
	logic cycle_status1_n_oe_out, latched_addr_bit20_out, slot_addr_bit20_out;
	logic slot_high_byte_en_n_out, mem_rd_n_out, mem_wr_n_out, io_rd_n_out, io_wr_n_out;
	logic [25:2] local_addr_in;
	logic [3:0] byte_en_n_in;
	logic [23:17] latched_upper_addr_out;
	logic [19:0] slot_addr_out;
	int n_mismatch = 0;
	int total_checks = 0;
	wire [4:0] cmds = {mem_rd_n_out, mem_wr_n_out, io_rd_n_out, io_wr_n_out, int_ack_n_out};
	wire [27:0] addrs = {latched_upper_addr_out, slot_addr_out, slot_high_byte_en_n_out};
	wire [1:0] b20 = {latched_addr_bit20_out, slot_addr_bit20_out};
	wire [4:0] pins = {cycle_status0_n_oe_out, cycle_status1_n_oe_out, cycle_status0_n_in,
		cycle_status1_n_in, bus_drive_en_out};
	hcsi_core dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
		.cycle_status0_n_in(cycle_status0_n_in),
		.cycle_status0_n_out(cycle_status0_n_out),
		.cycle_status0_n_oe_out(cycle_status0_n_oe_out),
		.cycle_status1_n_in(cycle_status1_n_in),
		.cycle_status1_n_out(cycle_status1_n_out),
		.cycle_status1_n_oe_out(cycle_status1_n_oe_out),
		.mem_io_select_in(mem_io_select_in),
		.early_addr_latch_n_in(early_addr_latch_n_in),
		.onboard_dram_sel_n_in(onboard_dram_sel_n_in),
		.addr_bit20_block_n_in(addr_bit20_block_n_in),
		.cpu_hold_ack_in(cpu_hold_ack_in), .channel_ready_n_out(channel_ready_n_out),
		.local_addr_in(local_addr_in), .byte_en_n_in(byte_en_n_in),
		.slot_clock_out(slot_clock_out),
		.latched_upper_addr_out(latched_upper_addr_out),
		.latched_addr_bit20_out(latched_addr_bit20_out),
		.slot_addr_out(slot_addr_out), .slot_addr_bit20_out(slot_addr_bit20_out),
		.slot_high_byte_en_n_out(slot_high_byte_en_n_out),
		.bus_drive_en_out(bus_drive_en_out),
		.mem_rd_n_out(mem_rd_n_out), .mem_wr_n_out(mem_wr_n_out),
		.io_rd_n_out(io_rd_n_out), .io_wr_n_out(io_wr_n_out),
		.int_ack_n_out(int_ack_n_out), .cycle_done_in(cycle_done_in),
		.dma_mem_wr_n_in(dma_mem_wr_n_in), .dma_mem_rd_n_in(dma_mem_rd_n_in));
	hcsi_sc_model sc (.clk_in(ref_clk_in), .s0_oe_in(cycle_status0_n_oe_out),
		.s0_dev_in(cycle_status0_n_out), .s1_oe_in(cycle_status1_n_oe_out),
		.s1_dev_in(cycle_status1_n_out), .s0_pin_out(cycle_status0_n_in),
		.s1_pin_out(cycle_status1_n_in), .mio_out(mem_io_select_in),
		.latch_n_out(early_addr_latch_n_in), .dram_n_out(onboard_dram_sel_n_in),
		.addr_out(local_addr_in), .be_n_out(byte_en_n_in));
	initial forever #10 ref_clk_in = ~ref_clk_in;
	task automatic check(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask : check
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask : step
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	task automatic idle_case();
		logic prev;
		check({channel_ready_n_out, cmds, bus_drive_en_out} === 7'h3F, "idle");
		prev = slot_clock_out;
		step(1);
		check(slot_clock_out === ~prev, "slot clock");
	endtask : idle_case
	task automatic run_cycle(input logic s0, s1, mio, dram_n, input logic [4:0] exp);
		sc.request(s0, s1, mio, dram_n, TA);
		step(0);
		check({channel_ready_n_out, cmds} === {1'b1, exp}, "start");
		check(addrs === {TA[23:17], TA[19:2], 3'h2}, "address");
		@(posedge ref_clk_in);
		cycle_done_in <= 1'b1;
		@(posedge ref_clk_in);
		cycle_done_in <= 1'b0;
		step(0);
		for (int i = 0; i < 4 && channel_ready_n_out !== 1'b0; i++) step(1);
		check({channel_ready_n_out, cmds} === {1'b0, exp}, "ready");
		step(1);
		check(cmds === 5'h1F, "end");
		check(latched_upper_addr_out === TA[23:17], "latch hold");
		sc.request(1'b0, 1'b0, 1'b1, 1'b1, TA);
		step(0);
		check(channel_ready_n_out === 1'b0, "idle");
	endtask : run_cycle
	task automatic pin_mode_case();
		check(b20 === {2{TA[20]}}, "bit 20 open");
		@(posedge ref_clk_in);
		addr_bit20_block_n_in <= 1'b0;
		step(4);
		check(b20 === 2'h0, "bit 20 low");
		@(posedge ref_clk_in);
		cpu_hold_ack_in <= 1'b1;
		step(4);
		check(b20 === {2{TA[20]}}, "bit 20");
		check(pins === 5'h1A, "hold");
		@(posedge ref_clk_in);
		{dma_mem_wr_n_in, dma_mem_rd_n_in} <= 2'h2;
		step(1);
		check(pins === 5'h1C, "hold strobes");
	endtask : pin_mode_case
	initial begin
		repeat (8) @(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
		step(5);
		idle_case();
		run_cycle(1'b1, 1'b0, 1'b1, 1'b1, 5'h17);
		run_cycle(1'b1, 1'b0, 1'b0, 1'b1, 5'h1D);
		run_cycle(1'b0, 1'b1, 1'b1, 1'b1, 5'h0F);
		run_cycle(1'b0, 1'b1, 1'b0, 1'b1, 5'h1B);
		run_cycle(1'b1, 1'b1, 1'b1, 1'b1, 5'h1E);
		run_cycle(1'b0, 1'b1, 1'b1, 1'b0, 5'h1F);
		pin_mode_case();
		tally_and_finish();
	end
	// the sequence needs about 130 cycles, so a hang is cut off well past that
	initial begin
		repeat (2000) @(posedge ref_clk_in);
		n_mismatch++;
		tally_and_finish();
	end
endmodule : testbench
